/* hdl/tspl_pkg.sv */
package tspl_pkg;
    localparam logic [7:0] TSPL_ADDR_PROG = 8'hC8;
    localparam logic [7:0] TSPL_ADDR_TONE = 8'hCC;
    localparam logic [7:0] TSPL_ADDR_MAIN = 8'hC6;
    localparam int TSPL_CLK_HZ = 40000000;
    localparam int TSPL_PROG_TIME_US = 250;
    localparam int TSPL_PROG_CYCLES = TSPL_PROG_TIME_US * (TSPL_CLK_HZ / 1000000);
    localparam int TSPL_PROG_CW = 14;
    localparam logic [5:0] TSPL_SUB_NONE = 6'h00;
    localparam logic [5:0] TSPL_SUB_INVALID = 6'h37;
    localparam logic [4:0] TSPL_SEL_NONE = 5'h00;
    localparam logic [4:0] TSPL_SEL_UNREC = 5'h1F;
    localparam logic [2:0] TSPL_DCS_NONE = 3'h0;
    localparam logic [2:0] TSPL_DCS_NORM = 3'h2;
    localparam logic [2:0] TSPL_DCS_INV = 3'h3;
    localparam logic [2:0] TSPL_DCS_OFF = 3'h5;
    localparam int TSPL_B_FIRST = 15;
    localparam int TSPL_B_SEL12 = 14;
    localparam int TSPL_ST_SEL = 13;
    localparam int TSPL_ST_SUB = 11;
    localparam int TSPL_ST_DCS = 10;
    localparam logic [1:0] TSPL_BLK0 = 2'h0;
    localparam logic [1:0] TSPL_BLK1 = 2'h1;
    localparam logic [1:0] TSPL_BLK2 = 2'h2;
    localparam logic [4:0] TSPL_LEN0 = 5'h04;
    localparam logic [4:0] TSPL_LEN1 = 5'h13;
    localparam logic [4:0] TSPL_LEN2 = 5'h05;
    localparam logic [4:0] TSPL_LEN4 = 5'h08;
    localparam logic [15:0] TSPL_SYNC_DEF = 16'hC4D7;
    localparam logic [15:0] TSPL_DATA_FRAME_SYNC_PATTERN_DEF = 16'hB433;
    typedef enum logic [2:0] {TSPL_B0, TSPL_B1, TSPL_B2, TSPL_B4, TSPL_BNONE} tspl_blk_e;
endpackage

/* hdl/tspl_top.sv */
`timescale 1ns/1ps
// Functional notes
// - Bits 5..0 give detected sub-audio tone index, zero when none.
// - Any non-selected sub-audio tone reports code 55.
// - Sub-audio field change sets status bit 11, except none to invalid.
// - Bits 15..11 give selective-call tone index, zero when none.
// - Selective-call change sets status bit 13, except unrecognised/none swaps.
// - Bits 10..8 encode none, DCS, inverted DCS, turn-off tone.
// - DCS/special report forces tone field zero; a detected tone does not clear bits 10..8.
// - Any change of bits 10..8 in receive sets DCS change flag; clearing in transmit does not.
// - Disabled modes read zero in receive; fields hold outside receive and transmit; whole word zero in transmit.
// - Bits 7 and 6 always read zero.
// - DCS code loss and return or turn-off each flag a change.
// - Bits 13..12 select block 0, 1 or 2; code 11 reserved.
// - A write outside receive and transmit clears ready; ready returns after 250 us.
// - Words go in listed order from the first word; blocks any order.
// - Leaving reset without keep bit reloads default values.
// - Block 1 holds level, threshold, repeat, 15 tones, reserved word.
// - Block 0 holds frame sync and data sync bytes, low first.
// - Status bits 13, 11, 10 flag events; reading clears bits 15..1.
module tspl_top
    import tspl_pkg::*;
#(
    parameter int PROG_CYCLES = TSPL_PROG_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic tx_mode_i,
    input wire logic rx_mode_i,
    input wire logic sub_en_i,
    input wire logic dcs_en_i,
    input wire logic sel_en_i,
    input wire logic dsp_rst_i,
    input wire logic keep_prog_i,
    input wire logic [5:0] det_sub_i,
    input wire logic det_sub_other_i,
    input wire logic [2:0] det_dcs_i,
    input wire logic [4:0] det_sel_i,
    output logic [15:0] rdata_o,
    output logic prog_ready_o,
    output logic order_err_o,
    output logic [15:0] sync_pattern_o,
    output logic [15:0] data_sync_pattern_o,
    output logic [11:0] blk1_word_o,
    output logic [4:0] blk1_index_o,
    output logic blk1_load_o,
    output logic [13:0] prog_data_o,
    output logic [2:0] prog_block_o,
    output logic [4:0] prog_index_o,
    output logic prog_load_o
);
    logic [5:0] sub_f;
    logic [2:0] dcs_f;
    logic [4:0] sel_f;
    logic [15:0] main_st;
    logic [TSPL_PROG_CW-1:0] busy_cnt;
    logic dsp_rst_d;
    tspl_blk_e cur_blk;
    logic [4:0] widx;

    wire rx_act = rx_mode_i && !tx_mode_i;
    wire [5:0] sub_raw = det_sub_other_i ? TSPL_SUB_INVALID : det_sub_i;
    wire dcs_legal = (det_dcs_i == TSPL_DCS_NORM) || (det_dcs_i == TSPL_DCS_INV)
                     || (det_dcs_i == TSPL_DCS_OFF);
    wire [2:0] dcs_in = (dcs_en_i && dcs_legal) ? det_dcs_i : TSPL_DCS_NONE;
    wire [5:0] sub_in = (sub_en_i && dcs_in == TSPL_DCS_NONE) ? sub_raw : TSPL_SUB_NONE;
    wire [4:0] sel_in = sel_en_i ? det_sel_i : TSPL_SEL_NONE;
    wire sub_chg = (sub_in != sub_f) &&
                   !(sub_f == TSPL_SUB_NONE && sub_in == TSPL_SUB_INVALID);
    wire sel_chg = (sel_in != sel_f) &&
                   !((sel_f == TSPL_SEL_UNREC && sel_in == TSPL_SEL_NONE) ||
                     (sel_f == TSPL_SEL_NONE && sel_in == TSPL_SEL_UNREC));
    // DCS change incl. loss and return
    wire dcs_chg = dcs_in != dcs_f;

    wire [15:0] tone_word = {sel_f, dcs_f, 2'b00, sub_f};
    wire rd_tone = rd_i && addr_i == TSPL_ADDR_TONE;
    wire rd_main = rd_i && addr_i == TSPL_ADDR_MAIN;
    wire wr_prog = wr_i && addr_i == TSPL_ADDR_PROG;
    // zero in transmit
    // Gate here too: fields clear one edge after transmit starts
    wire [15:0] tone_rd = tx_mode_i ? 16'h0000 : tone_word;
    wire [15:0] next_rdata = rd_tone ? tone_rd : (rd_main ? main_st : 16'h0000);

    wire w_first = wdata_i[TSPL_B_FIRST];
    wire [1:0] w_bsel = wdata_i[13:12];
    tspl_blk_e w_blk;
    assign w_blk = !wdata_i[TSPL_B_SEL12] ? TSPL_B4 :
                   (w_bsel == TSPL_BLK0) ? TSPL_B0 :
                   (w_bsel == TSPL_BLK1) ? TSPL_B1 :
                   (w_bsel == TSPL_BLK2) ? TSPL_B2 : TSPL_BNONE;
    wire [4:0] blk_len = (w_blk == TSPL_B0) ? TSPL_LEN0 :
                         (w_blk == TSPL_B1) ? TSPL_LEN1 :
                         (w_blk == TSPL_B2) ? TSPL_LEN2 : TSPL_LEN4;
    wire [13:0] w_data = (w_blk == TSPL_B4) ? wdata_i[13:0] : {2'b00, wdata_i[11:0]};
    wire [4:0] next_widx = w_first ? 5'h00 : widx + 5'h01;
    wire w_ok = (w_blk != TSPL_BNONE) && (w_first || w_blk == cur_blk) && next_widx < blk_len;
    wire accept = wr_prog && prog_ready_o && !rx_mode_i && !tx_mode_i;
    wire reload = dsp_rst_d && !dsp_rst_i && !keep_prog_i;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sub_f <= TSPL_SUB_NONE;
            dcs_f <= TSPL_DCS_NONE;
            sel_f <= TSPL_SEL_NONE;
        end else if (tx_mode_i) begin
            sub_f <= TSPL_SUB_NONE;
            dcs_f <= TSPL_DCS_NONE;
            sel_f <= TSPL_SEL_NONE;
        end else if (rx_act) begin
            sub_f <= sub_in;
            dcs_f <= dcs_in;
            sel_f <= sel_in;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            main_st <= 16'h0000;
        end else begin
            main_st[15:1] <= (rd_main ? 15'h0000 : main_st[15:1]);
            if (rx_act && sel_chg) main_st[TSPL_ST_SEL] <= 1'b1;
            if (rx_act && sub_chg) main_st[TSPL_ST_SUB] <= 1'b1;
            if (rx_act && dcs_chg) main_st[TSPL_ST_DCS] <= 1'b1;
            main_st[0] <= prog_ready_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= 16'h0000;
            dsp_rst_d <= 1'b1;
        end else begin
            rdata_o <= next_rdata;
            dsp_rst_d <= dsp_rst_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prog_ready_o <= 1'b1;
            busy_cnt <= '0;
            order_err_o <= 1'b0;
            cur_blk <= TSPL_BNONE;
            widx <= 5'h00;
            prog_load_o <= 1'b0;
            blk1_load_o <= 1'b0;
            prog_data_o <= 14'h0000;
            prog_block_o <= 3'h0;
            prog_index_o <= 5'h00;
            blk1_word_o <= 12'h000;
            blk1_index_o <= 5'h00;
            sync_pattern_o <= TSPL_SYNC_DEF;
            data_sync_pattern_o <= TSPL_DATA_FRAME_SYNC_PATTERN_DEF;
        end else begin
            prog_load_o <= 1'b0;
            blk1_load_o <= 1'b0;
            if (reload) begin
                sync_pattern_o <= TSPL_SYNC_DEF;
                data_sync_pattern_o <= TSPL_DATA_FRAME_SYNC_PATTERN_DEF;
                cur_blk <= TSPL_BNONE;
            end else if (accept) begin
                prog_ready_o <= 1'b0;
                busy_cnt <= TSPL_PROG_CW'(PROG_CYCLES - 1);
                order_err_o <= !w_ok;
                if (w_ok) begin
                    cur_blk <= w_blk;
                    widx <= next_widx;
                    prog_load_o <= 1'b1;
                    prog_data_o <= w_data;
                    prog_block_o <= 3'(w_blk);
                    prog_index_o <= next_widx;
                    if (w_blk == TSPL_B0) begin
                        unique case (next_widx[1:0])
                            2'h0: sync_pattern_o[7:0] <= wdata_i[7:0];
                            2'h1: sync_pattern_o[15:8] <= wdata_i[7:0];
                            2'h2: data_sync_pattern_o[7:0] <= wdata_i[7:0];
                            2'h3: data_sync_pattern_o[15:8] <= wdata_i[7:0];
                        endcase
                    end
                    if (w_blk == TSPL_B1) begin
                        blk1_load_o <= 1'b1;
                        blk1_word_o <= wdata_i[11:0];
                        blk1_index_o <= next_widx;
                    end
                end else begin
                    cur_blk <= TSPL_BNONE;
                end
            end else if (!prog_ready_o) begin
                if (busy_cnt == '0) prog_ready_o <= 1'b1;
                else busy_cnt <= busy_cnt - 1'b1;
            end
        end
    end
endmodule

/* verif/tspl_host_model.sv */
`timescale 1ns/1ps
module tspl_host_model
    import tspl_pkg::*;
(
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic ready_i,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic [7:0] addr_o = 8'h00,
    output logic [15:0] wdata_o = 16'h0000
);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
            output logic [15:0] q);
        @(posedge clk_i);
        wr_o <= w;
        rd_o <= !w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        // Released bus shows the inverse, not a stale copy
        wdata_o <= ~d;
        @(negedge clk_i);
        q = rdata_i;
        @(posedge clk_i);
    endtask
    task automatic prog_write(input logic [15:0] d);
        logic [15:0] q;
        @(posedge clk_i);
        repeat (40) if (ready_i !== 1'b1) @(posedge clk_i);
        xfer(1'b1, TSPL_ADDR_PROG, d, q);
    endtask
endmodule

/* verif/tspl_top_monitor.sv */
`timescale 1ns/1ps
module tspl_top_monitor
    import tspl_pkg::*;
#(
    parameter int PROG_CYCLES = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic tx_mode_i,
    input wire logic rx_mode_i,
    input wire logic [15:0] rdata_o,
    input wire logic prog_ready_o,
    input wire logic order_err_o,
    input wire logic [13:0] prog_data_o,
    input wire logic [2:0] prog_block_o,
    input wire logic prog_load_o,
    input wire logic blk1_load_o
);
    localparam int LIM = PROG_CYCLES + 1;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire acc = wr_i && addr_i == TSPL_ADDR_PROG && prog_ready_o && !rx_mode_i && !tx_mode_i;
    wire rdt = rd_i && addr_i == TSPL_ADDR_TONE;
    wire [13:0] wlow = wdata_i[13:0];
    rsv_zero_a: assert property (rdt |=> rdata_o[7:6] == 2'h0) else $error("bits 7:6 set");
    tx_zero_a: assert property (rdt && tx_mode_i |=> rdata_o == 16'h0000) else $error("tx");
    tone_excl_a: assert property (rdt |=> rdata_o[10:8] == 3'h0 || rdata_o[5:0] == 6'h00)
        else $error("x");
    rdy_drop_a: assert property (acc |=> !prog_ready_o) else $error("ready kept");
    rdy_back_a: assert property ($fell(prog_ready_o) |-> ##[PROG_CYCLES:LIM] prog_ready_o) else $error("r");
    busy_ign_a: assert property (wr_i && !prog_ready_o |=> !prog_load_o) else $error("busy");
    rsv_blk_a: assert property (acc && wdata_i[15:12] == 4'hF |=> order_err_o && !prog_load_o) else $error("rb");
    blk4_load_a: assert property (acc && wdata_i[15:14] == 2'h2 |=>
        prog_load_o && prog_block_o == 3'h3 && prog_data_o == $past(wlow)) else $error("block 4");
    blk1_load_a: assert property (acc && wdata_i[15:12] == 4'hD |=> blk1_load_o)
        else $error("block 1");
    cover property (acc);
    cover property (rdt && tx_mode_i);
    cover property ($fell(prog_ready_o));
endmodule

/* verif/tspl_top_test.sv */
`timescale 1ns/1ps
module tspl_top_test
    import tspl_pkg::*;
;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic tx = 1'b0, rx = 1'b0, den = 1'b1, drst = 1'b0, oth = 1'b0;
    logic sen = 1'b1, cen = 1'b1, kp = 1'b0;
    logic [11:0] bword;
    logic [4:0] bidx, pidx;
    logic [5:0] sub = 6'h00;
    logic [2:0] dcs = 3'h0;
    logic [4:0] sel = 5'h00;
    logic wr, rd, rdy, oerr;
    logic [7:0] addr;
    logic [15:0] wd, rdat, sync, dsync, q;
    logic [15:0] blk0 [4] = '{16'hC0AB, 16'h40CD, 16'h4012, 16'h4034};
    int fails = 0, samples_checked = 0, cyc = 0;
    always #12.5 clk_i = ~clk_i;
    tspl_top #(.PROG_CYCLES(8)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_i(wr),
        .rd_i(rd), .addr_i(addr), .wdata_i(wd), .tx_mode_i(tx), .rx_mode_i(rx),
        .sub_en_i(sen), .dcs_en_i(den), .sel_en_i(cen), .dsp_rst_i(drst), .keep_prog_i(kp),
        .det_sub_i(sub), .det_sub_other_i(oth), .det_dcs_i(dcs), .det_sel_i(sel), .rdata_o(rdat),
        .prog_ready_o(rdy), .order_err_o(oerr), .sync_pattern_o(sync),
        .data_sync_pattern_o(dsync), .blk1_word_o(bword), .blk1_index_o(bidx), .blk1_load_o(),
        .prog_data_o(), .prog_block_o(), .prog_index_o(pidx), .prog_load_o());
    tspl_host_model u_host (.clk_i(clk_i), .rdata_i(rdat), .ready_i(rdy), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wd));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string n);
        repeat (2) @(posedge clk_i);
        u_host.xfer(1'b0, a, 16'h0000, q);
        chk(n, e, q);
    endtask
    task automatic dsp_pulse();
        drst <= 1'b1;
        repeat (3) @(posedge clk_i);
        drst <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic stop_test(input logic to);
        fails += int'(to);
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i) if (cyc++ == 4000) stop_test(1'b1);
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rdc(TSPL_ADDR_TONE, 16'h0000, "tone reset");
        rdc(TSPL_ADDR_MAIN, 16'h0001, "main reset");
        rx <= 1'b1;
        sub <= 6'h05;
        rdc(TSPL_ADDR_TONE, 16'h0005, "tone index");
        rdc(TSPL_ADDR_MAIN, 16'h0801, "tone flag");
        rdc(TSPL_ADDR_MAIN, 16'h0001, "flag clear");
        sub <= 6'h00;
        rdc(TSPL_ADDR_MAIN, 16'h0801, "tone lost");
        oth <= 1'b1;
        rdc(TSPL_ADDR_MAIN, 16'h0001, "none to invalid");
        rdc(TSPL_ADDR_TONE, 16'h0037, "invalid code");
        dcs <= TSPL_DCS_INV;
        sub <= 6'h05;
        rdc(TSPL_ADDR_TONE, 16'h0300, "dcs masks tone");
        rdc(TSPL_ADDR_MAIN, 16'h0C01, "dcs flag");
        oth <= 1'b0;
        dcs <= TSPL_DCS_NONE;
        rdc(TSPL_ADDR_MAIN, 16'h0C01, "dcs loss");
        dcs <= TSPL_DCS_OFF;
        sel <= 5'h07;
        rdc(TSPL_ADDR_TONE, 16'h3D00, "selcall index");
        rdc(TSPL_ADDR_MAIN, 16'h2C01, "selcall flag");
        sel <= 5'h00;
        rdc(TSPL_ADDR_MAIN, 16'h2001, "selcall lost");
        sel <= TSPL_SEL_UNREC;
        rdc(TSPL_ADDR_MAIN, 16'h0001, "none to unrec");
        den <= 1'b0;
        rdc(TSPL_ADDR_TONE, 16'hF805, "dcs disabled");
        sen <= 1'b0;
        rdc(TSPL_ADDR_TONE, 16'hF800, "sub disabled");
        tx <= 1'b1;
        rdc(TSPL_ADDR_TONE, 16'h0000, "transmit");
        tx <= 1'b0;
        cen <= 1'b0;
        rdc(TSPL_ADDR_TONE, 16'h0000, "selcall disabled");
        rx <= 1'b0;
        foreach (blk0[i]) u_host.prog_write(blk0[i]);
        chk("sync", 16'hCDAB, sync);
        chk("data sync", 16'h3412, dsync);
        u_host.prog_write(16'h4099);
        chk("overrun", 16'h0001, {15'h0000, oerr});
        u_host.prog_write(16'hF000);
        chk("reserved block", 16'h0001, {15'h0000, oerr});
        u_host.prog_write(16'h8123);
        chk("block 4 start", 16'h0000, {15'h0000, oerr});
        u_host.prog_write(16'hD123);
        u_host.prog_write(16'h5456);
        chk("blk1 word", 16'h1456, {bidx[3:0], bword});
        chk("prog index", 16'h0001, {11'h000, pidx});
        u_host.prog_write(16'hC0EE);
        u_host.xfer(1'b1, TSPL_ADDR_PROG, 16'hC011, q);
        rx <= 1'b1;
        u_host.prog_write(16'hC022);
        chk("refused writes", 16'hCDEE, sync);
        rx <= 1'b0;
        kp <= 1'b1;
        dsp_pulse();
        chk("sync kept", 16'hCDEE, sync);
        kp <= 1'b0;
        dsp_pulse();
        chk("sync reload", 16'hC4D7, sync);
        chk("data sync reload", 16'hB433, dsync);
        stop_test(1'b0);
    end
endmodule
bind tspl_top tspl_top_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.clk_i, .sys_rst_i, .wr_i,
    .rd_i, .addr_i, .wdata_i, .tx_mode_i, .rx_mode_i, .rdata_o, .prog_ready_o, .order_err_o,
    .prog_data_o, .prog_block_o, .prog_load_o, .blk1_load_o);
